//--- logic/shsp_ctrl.sv
`timescale 1ns/1ps
`include "shsp_regs.svh"

// ----------------------------------------
// Summary of operation
// - Non-open key value turns protection on
// - Key value 1fh turns protection off
// - Protect status readable in noise control
// - Reset clears protection
// - Critical registers protected, key and idle run register stay writable
// - Halt select picks light, deep, stop
// - Light idle: units run per enable
// - Deep idle: oscillator and clock timer only
// - Stop: everything halts, oscillator too
// - Level at least mask: wake and service
// - Low lines, clock timer wake without service
// - Non-maskable interrupt always wakes, serviced
// - Wake sources depend on halt state
// - Stop wake waits for warm-up
// - Requests during entry are held pending
// - Reset releases halt, reinitialises settings
// - Interrupt wake keeps register settings, clears held requests
// - Deep idle samples async, restarts sync
// - System clock held until warm-up ends
// ----------------------------------------
module shsp_ctrl import shsp_pkg::*; #(
    parameter int N_BANK = 13,
    parameter int N_UNITS = 11,
    parameter int WARM_MID = 16384,
    parameter int WARM_LONG = 65536
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // CPU core and interrupt controller
    input wire logic halt_exec_in,
    input wire logic [2:0] interrupt_mask_level_in,
    input wire logic [2:0] irq_level_in,
    input wire logic watchdog_irq_in,
    input wire logic clock_timer_irq_in,
    input wire logic periph_irq_in,
    // Interrupt pins
    input wire logic nmi_in,
    input wire logic [4:0] ext_irq_low_group_in,
    input wire logic [3:0] ext_irq_high_group_in,
    // Standby controls
    output logic cpu_stop_out,
    output logic sys_clk_en_out,
    output logic osc_en_out,
    output logic clock_timer_run_out,
    output logic port_hold_out,
    output logic [N_UNITS-1:0] periph_run_out,
    output logic wake_service_out,
    output logic wake_resume_out,
    output logic [10:0] irq_held_out,
    output logic protect_on_out
);

    if (N_BANK < 1 || N_BANK > 16 || N_UNITS < 6 || N_UNITS > 32 || WARM_MID < 1 || WARM_LONG < 1
        || WARM_MID > 131071 || WARM_LONG > 131071) begin : g_bad_param
        $error("unsupported parameter value");
    end

    localparam logic [16:0] WARM_MID_C = 17'(WARM_MID);
    localparam logic [16:0] WARM_LONG_C = 17'(WARM_LONG);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [9:0] pin_raw;
    logic [9:0] pin_s1_ff;
    logic [9:0] pin_s2_ff;
    assign pin_raw = {ext_irq_high_group_in, ext_irq_low_group_in, nmi_in};

    // Two stages per pin, asynchronous sampling of requests
    for (genvar i = 0; i < 10; i++) begin : g_sync
        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                pin_s1_ff[i] <= 1'b0;
                pin_s2_ff[i] <= 1'b0;
            end else begin
                pin_s1_ff[i] <= pin_raw[i];
                pin_s2_ff[i] <= pin_s1_ff[i];
            end
        end
    end

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    logic awready_ff, arready_ff, bvalid_ff, rvalid_ff, rd_pend_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [31:0] rdata_ff;
    logic [7:0] rd_addr_ff;
    logic protect_ff;
    shsp_byte_t noise_ff, sc0_ff, sc1_ff, sc2_ff, flash_ff;
    logic [N_UNITS-1:0] idle_run_ff;
    shsp_byte_t bank_rd;
    shsp_state_e st_ff, nxt_st;
    logic [10:0] held_ff, nxt_held;

    // Address decode
    wire [7:0] wr_addr = s_axi_awaddr_in;
    wire [7:0] aw_off = wr_addr - `SHSP_ADDR_BANK;
    wire [7:0] ar_off = s_axi_araddr_in - `SHSP_ADDR_BANK;
    wire [7:0] rd_off = rd_addr_ff - `SHSP_ADDR_BANK;
    wire aw_bank = wr_addr >= `SHSP_ADDR_BANK && aw_off[1:0] == 2'h0 && int'(aw_off[7:2]) < N_BANK;
    wire rd_bank = rd_addr_ff >= `SHSP_ADDR_BANK && rd_off[1:0] == 2'h0 && int'(rd_off[7:2]) < N_BANK;
    wire wr_fire = awready_ff && s_axi_awvalid_in && s_axi_wvalid_in;
    wire wr_ok = wr_fire && s_axi_wstrb_in[0];
    wire shsp_byte_t wbyte = s_axi_wdata_in[7:0];
    wire wr_open = wr_ok && !protect_ff;
    wire aw_known = aw_bank || wr_addr <= `SHSP_ADDR_STAT && wr_addr[1:0] == 2'h0;
    wire rd_known = rd_bank || rd_addr_ff <= `SHSP_ADDR_STAT && rd_addr_ff[1:0] == 2'h0;
    wire ar_fire = arready_ff && s_axi_arvalid_in;

    // Read data selection
    wire shsp_byte_t noise_rd = {noise_ff[7:6], protect_ff, noise_ff[4:0]};
    wire [31:0] stat_rd = {27'h0000000, held_ff != 11'h000, protect_ff, 3'(st_ff)};
    wire [31:0] rd_mux =
        rd_bank ? {24'h000000, bank_rd} :
        rd_addr_ff == `SHSP_ADDR_KEY ? 32'h00000000 :
        rd_addr_ff == `SHSP_ADDR_NOISE ? {24'h000000, noise_rd} :
        rd_addr_ff == `SHSP_ADDR_SC0 ? {24'h000000, sc0_ff} :
        rd_addr_ff == `SHSP_ADDR_SC1 ? {24'h000000, sc1_ff} :
        rd_addr_ff == `SHSP_ADDR_SC2 ? {24'h000000, sc2_ff} :
        rd_addr_ff == `SHSP_ADDR_FLASH ? {24'h000000, flash_ff} :
        rd_addr_ff == `SHSP_ADDR_IDLE ? 32'(idle_run_ff) :
        rd_addr_ff == `SHSP_ADDR_STAT ? stat_rd : 32'h00000000;

    // Write handshake: both channels taken together
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            awready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `SHSP_RESP_OKAY;
        end else begin
            awready_ff <= !awready_ff && !bvalid_ff && s_axi_awvalid_in && s_axi_wvalid_in;
            if (wr_fire) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= aw_known ? `SHSP_RESP_OKAY : `SHSP_RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Read handshake with one cycle for the bank memory
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            arready_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rd_addr_ff <= 8'h00;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `SHSP_RESP_OKAY;
        end else begin
            arready_ff <= !arready_ff && !rd_pend_ff && !rvalid_ff && s_axi_arvalid_in;
            rd_pend_ff <= ar_fire;
            if (ar_fire) begin
                rd_addr_ff <= s_axi_araddr_in;
            end
            if (rd_pend_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux;
                rresp_ff <= rd_known ? `SHSP_RESP_OKAY : `SHSP_RESP_SLVERR;
            end else if (s_axi_rready_in) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // Key and critical registers
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            protect_ff <= 1'b0;
            noise_ff <= `SHSP_NOISE_RST;
            sc0_ff <= `SHSP_SC0_RST;
            sc1_ff <= `SHSP_SC1_RST;
            sc2_ff <= `SHSP_SC2_RST;
            flash_ff <= `SHSP_FLASH_RST;
            idle_run_ff <= '0;
        end else if (wr_ok) begin
            if (wr_addr == `SHSP_ADDR_KEY) begin
                protect_ff <= wbyte != `SHSP_KEY_OPEN;
            end
            if (wr_open && wr_addr == `SHSP_ADDR_NOISE) noise_ff <= wbyte;
            if (wr_open && wr_addr == `SHSP_ADDR_SC0) sc0_ff <= wbyte;
            if (wr_open && wr_addr == `SHSP_ADDR_SC1) sc1_ff <= wbyte;
            if (wr_open && wr_addr == `SHSP_ADDR_SC2) sc2_ff <= wbyte;
            if (wr_open && wr_addr == `SHSP_ADDR_FLASH) flash_ff <= wbyte;
            if (wr_addr == `SHSP_ADDR_IDLE) idle_run_ff <= N_UNITS'(s_axi_wdata_in);
        end
    end

    // Chip-select and wait bank
    shsp_bank_mem #(.DEPTH(N_BANK), .AW(4)) u_bank (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .wr_en_in(wr_open && aw_bank),
        .wr_idx_in(aw_off[5:2]),
        .wr_data_in(wbyte),
        .rd_idx_in(ar_off[5:2]),
        .rd_data_out(bank_rd)
    );

    // ----------------------------------------
    // Standby controller
    // ----------------------------------------
    logic [2:0] enter_cnt_ff, nxt_enter_cnt;
    logic [16:0] warm_cnt_ff, nxt_warm_cnt;
    logic tgt_stop_ff, nxt_tgt_stop, warm_svc_ff, nxt_warm_svc, nxt_svc, nxt_res;

    // Wake source qualification per halt state
    wire nmi_s = pin_s2_ff[0];
    wire any_low = |pin_s2_ff[5:1];
    wire tb_ok = idle_run_ff[`SHSP_IR_TB0] && idle_run_ff[`SHSP_IR_TB1];
    wire high_ok = |pin_s2_ff[9:6] && tb_ok;
    wire lvl_ok = irq_level_in >= interrupt_mask_level_in;
    wire light_src = watchdog_irq_in || high_ok || periph_irq_in || clock_timer_irq_in || any_low;
    wire light_svc = nmi_s || lvl_ok && light_src;
    wire low_res = !lvl_ok && (any_low || clock_timer_irq_in);
    wire deep_svc = nmi_s || lvl_ok && (any_low || clock_timer_irq_in);
    wire stop_wake = nmi_s || any_low;
    wire [10:0] wake_src = {clock_timer_irq_in, pin_s2_ff};
    wire [1:0] halt_sel = sc2_ff[`SHSP_HALT_HI:`SHSP_HALT_LO];
    wire [1:0] wup_sel = sc2_ff[`SHSP_WUP_HI:`SHSP_WUP_LO];
    wire [16:0] warm_load = wup_sel == `SHSP_WUP_LONG ? WARM_LONG_C :
                            wup_sel == `SHSP_WUP_MID ? WARM_MID_C : `SHSP_WARM_SHORT;

    // Next state
    always_comb begin
        nxt_st = st_ff;
        nxt_enter_cnt = enter_cnt_ff;
        nxt_warm_cnt = warm_cnt_ff;
        nxt_tgt_stop = tgt_stop_ff;
        nxt_warm_svc = warm_svc_ff;
        nxt_svc = 1'b0;
        nxt_res = 1'b0;
        case (st_ff)
            SHSP_RUN: begin
                if (halt_exec_in) begin
                    case (halt_sel)
                        `SHSP_HALT_LIGHT: nxt_st = SHSP_LIGHT;
                        `SHSP_HALT_DEEP, `SHSP_HALT_STOP: begin
                            nxt_st = SHSP_ENTER;
                            nxt_enter_cnt = `SHSP_ENTER_CLKS;
                            nxt_tgt_stop = halt_sel == `SHSP_HALT_STOP;
                        end
                        default: nxt_st = SHSP_RUN;
                    endcase
                end
            end
            SHSP_ENTER: begin
                nxt_enter_cnt = enter_cnt_ff - 3'h1;
                if (enter_cnt_ff == 3'h1) begin
                    nxt_st = tgt_stop_ff ? SHSP_STOP : SHSP_DEEP;
                end
            end
            SHSP_LIGHT: begin
                nxt_svc = light_svc;
                nxt_res = !light_svc && low_res;
            end
            SHSP_DEEP: begin
                nxt_svc = deep_svc;
                nxt_res = !deep_svc && low_res;
            end
            SHSP_STOP: begin
                if (stop_wake) begin
                    nxt_st = SHSP_WARM;
                    nxt_warm_cnt = warm_load;
                    nxt_warm_svc = nmi_s || lvl_ok;
                end
            end
            SHSP_WARM: begin
                nxt_warm_cnt = warm_cnt_ff - 17'h00001;
                if (warm_cnt_ff == 17'h00001) begin
                    nxt_svc = warm_svc_ff;
                    nxt_res = !warm_svc_ff;
                end
            end
            default: nxt_st = SHSP_RUN;
        endcase
        if (nxt_svc || nxt_res) begin
            nxt_st = SHSP_RUN;
        end
        nxt_held = (nxt_svc || nxt_res) ? 11'h000 : held_ff;
        if (st_ff == SHSP_ENTER) begin
            nxt_held = held_ff | wake_src;
        end
    end

    // State and standby outputs from the next state
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_ff <= SHSP_RUN;
            enter_cnt_ff <= 3'h0;
            warm_cnt_ff <= 17'h00000;
            tgt_stop_ff <= 1'b0;
            warm_svc_ff <= 1'b0;
            held_ff <= 11'h000;
            wake_service_out <= 1'b0;
            wake_resume_out <= 1'b0;
            cpu_stop_out <= 1'b0;
            sys_clk_en_out <= 1'b1;
            osc_en_out <= 1'b1;
            clock_timer_run_out <= 1'b1;
            port_hold_out <= 1'b0;
            periph_run_out <= '1;
        end else begin
            st_ff <= nxt_st;
            enter_cnt_ff <= nxt_enter_cnt;
            warm_cnt_ff <= nxt_warm_cnt;
            tgt_stop_ff <= nxt_tgt_stop;
            warm_svc_ff <= nxt_warm_svc;
            held_ff <= nxt_held;
            wake_service_out <= nxt_svc;
            wake_resume_out <= nxt_res;
            cpu_stop_out <= nxt_st != SHSP_RUN;
            sys_clk_en_out <= nxt_st == SHSP_RUN || nxt_st == SHSP_ENTER || nxt_st == SHSP_LIGHT;
            osc_en_out <= nxt_st != SHSP_STOP;
            clock_timer_run_out <= nxt_st != SHSP_STOP && nxt_st != SHSP_WARM;
            port_hold_out <= nxt_st != SHSP_RUN;
            periph_run_out <= nxt_st == SHSP_LIGHT ? idle_run_ff :
                              (nxt_st == SHSP_RUN || nxt_st == SHSP_ENTER) ? '1 : '0;
        end
    end

    assign s_axi_awready_out = awready_ff;
    assign s_axi_wready_out = awready_ff;
    assign s_axi_bvalid_out = bvalid_ff;
    assign s_axi_bresp_out = bresp_ff;
    assign s_axi_arready_out = arready_ff;
    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out = rdata_ff;
    assign s_axi_rresp_out = rresp_ff;
    assign irq_held_out = held_ff;
    assign protect_on_out = protect_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_deep_req;
        st_ff == SHSP_RUN && halt_exec_in && halt_sel == `SHSP_HALT_DEEP;
    endsequence
    sequence s_enter_done;
        (st_ff == SHSP_ENTER) [*5] ##1 st_ff == SHSP_DEEP;
    endsequence

    property p_prot_on;
        wr_ok && wr_addr == `SHSP_ADDR_KEY && wbyte != `SHSP_KEY_OPEN |=> protect_on_out;
    endproperty
    a_prot_on: assert property (p_prot_on) else $error("key write did not protect");
    property p_prot_off;
        wr_ok && wr_addr == `SHSP_ADDR_KEY && wbyte == `SHSP_KEY_OPEN |=> !protect_on_out;
    endproperty
    a_prot_off: assert property (p_prot_off) else $error("open key did not unlock");
    property p_prot_stat;
        $rose(rvalid_ff) && rd_addr_ff == `SHSP_ADDR_NOISE |-> rdata_ff[`SHSP_NOISE_PROT] == $past(protect_ff);
    endproperty
    a_prot_stat: assert property (p_prot_stat) else $error("protect status wrong");
    property p_block;
        wr_ok && protect_ff && aw_known && wr_addr != `SHSP_ADDR_KEY && wr_addr != `SHSP_ADDR_IDLE
            |=> $stable(sc0_ff) && $stable(sc2_ff) && $stable(flash_ff) && bresp_ff == `SHSP_RESP_OKAY;
    endproperty
    a_block: assert property (p_block) else $error("protected write took effect");
    property p_light;
        st_ff == SHSP_LIGHT && $past(st_ff) == SHSP_LIGHT |-> cpu_stop_out && periph_run_out == $past(idle_run_ff);
    endproperty
    a_light: assert property (p_light) else $error("light idle outputs wrong");
    property p_deep;
        st_ff == SHSP_DEEP |-> !sys_clk_en_out && osc_en_out && clock_timer_run_out && periph_run_out == '0;
    endproperty
    a_deep: assert property (p_deep) else $error("deep idle outputs wrong");
    property p_stop;
        st_ff == SHSP_STOP |-> !osc_en_out && !sys_clk_en_out && !clock_timer_run_out;
    endproperty
    a_stop: assert property (p_stop) else $error("stop outputs wrong");
    property p_nmi;
        (st_ff == SHSP_LIGHT || st_ff == SHSP_DEEP) && nmi_s |=> wake_service_out && st_ff == SHSP_RUN;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi did not wake");
    property p_resume;
        st_ff == SHSP_DEEP && !nmi_s && !lvl_ok && (any_low || clock_timer_irq_in) |=> wake_resume_out && !wake_service_out;
    endproperty
    a_resume: assert property (p_resume) else $error("low line did not resume");
    property p_no_wake;
        st_ff == SHSP_DEEP && !nmi_s && !any_low && !clock_timer_irq_in |=> st_ff == SHSP_DEEP;
    endproperty
    a_no_wake: assert property (p_no_wake) else $error("deep idle woke wrongly");
    property p_warm;
        st_ff == SHSP_STOP && any_low |=> st_ff == SHSP_WARM && !sys_clk_en_out && !wake_service_out;
    endproperty
    a_warm: assert property (p_warm) else $error("stop wake skipped warm-up");
    property p_enter;
        s_deep_req |=> s_enter_done;
    endproperty
    a_enter: assert property (p_enter) else $error("entry not five cycles");

endmodule

//--- logic/shsp_regs.svh
`ifndef SHSP_REGS_SVH
`define SHSP_REGS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SHSP_ADDR_KEY 8'h00
`define SHSP_ADDR_NOISE 8'h04
`define SHSP_ADDR_SC0 8'h08
`define SHSP_ADDR_SC1 8'h0c
`define SHSP_ADDR_SC2 8'h10
`define SHSP_ADDR_FLASH 8'h14
`define SHSP_ADDR_IDLE 8'h18
`define SHSP_ADDR_STAT 8'h1c
`define SHSP_ADDR_BANK 8'h40

// ----------------------------------------
// Values and fields
// ----------------------------------------
`define SHSP_KEY_OPEN 8'h1f
`define SHSP_NOISE_RST 8'h03
`define SHSP_NOISE_PROT 5
`define SHSP_SC0_RST 8'h00
`define SHSP_SC1_RST 8'h00
`define SHSP_SC2_RST 8'h2c
`define SHSP_FLASH_RST 8'h00
`define SHSP_BANK_RST 8'h00
`define SHSP_HALT_LO 2
`define SHSP_HALT_HI 3
`define SHSP_WUP_LO 4
`define SHSP_WUP_HI 5
`define SHSP_HALT_LIGHT 2'b11
`define SHSP_HALT_DEEP 2'b10
`define SHSP_HALT_STOP 2'b01
`define SHSP_WUP_SHORT 2'b01
`define SHSP_WUP_MID 2'b10
`define SHSP_WUP_LONG 2'b11
`define SHSP_IR_TB0 4
`define SHSP_IR_TB1 5

// ----------------------------------------
// Timing counts and bus answers
// ----------------------------------------
`define SHSP_ENTER_CLKS 3'h5
`define SHSP_WARM_SHORT 17'h00100
`define SHSP_RESP_OKAY 2'b00
`define SHSP_RESP_SLVERR 2'b10

`endif

//--- logic/shsp_pkg.sv
package shsp_pkg;

    // Standby controller states
    typedef enum logic [2:0] {
        SHSP_RUN,
        SHSP_ENTER,
        SHSP_LIGHT,
        SHSP_DEEP,
        SHSP_STOP,
        SHSP_WARM
    } shsp_state_e;

    typedef logic [7:0] shsp_byte_t;

endpackage

//--- logic/shsp_bank_mem.sv
`timescale 1ns/1ps
`include "shsp_regs.svh"

module shsp_bank_mem import shsp_pkg::*; #(
    parameter int DEPTH = 13,
    parameter int AW = 4
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_idx_in,
    input wire shsp_byte_t wr_data_in,
    // Read port
    input wire logic [AW-1:0] rd_idx_in,
    output shsp_byte_t rd_data_out
);

    shsp_byte_t mem_ff [DEPTH];
    shsp_byte_t rd_data_ff;

    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("bank depth does not fit index width");
    end

    // Entries reset to default on chip reset
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                mem_ff[i] <= `SHSP_BANK_RST;
            end else if (wr_en_in && wr_idx_in == AW'(i)) begin
                mem_ff[i] <= wr_data_in;
            end
        end
    end

    // Registered read data
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rd_data_ff <= `SHSP_BANK_RST;
        end else if (int'(rd_idx_in) < DEPTH) begin
            rd_data_ff <= mem_ff[rd_idx_in];
        end else begin
            rd_data_ff <= `SHSP_BANK_RST;
        end
    end

    assign rd_data_out = rd_data_ff;

endmodule

//--- test/shsp_cpu_model.sv
`timescale 1ns/1ps

// Far side: halt strobe and clock timer request
module shsp_cpu_model (
    // Clock, reset and commands
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic go_in,
    input wire logic req_in,
    input wire logic woke_in,
    // Requests to the block
    output logic halt_exec_out,
    output logic clock_timer_irq_out
);
    // Halt strobe lasts one cycle; request stays up until a wake is seen
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            halt_exec_out <= 1'b0;
            clock_timer_irq_out <= 1'b0;
        end else begin
            halt_exec_out <= go_in;
            clock_timer_irq_out <= req_in | (clock_timer_irq_out & ~woke_in);
        end
    end
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
`include "shsp_regs.svh"

module tb_top import shsp_pkg::*;;
    // Bench signals
    logic clk = 1'b0, rst = 1'b1, awv, wv, br, arv, rr, go, req, hx, ct, nmi, wdg;
    logic awr, wr_r, bv, arr, rv_o, stp, sclk, osc, ctr, ph, svc, rsm, prot;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, rv, seed = 32'd51541;
    logic [3:0] ws;
    logic [1:0] br_s, rr_s, rsp;
    logic [2:0] msk, lvl;
    logic [4:0] low;
    logic [10:0] prun, held, en;
    logic [7:0] pa [3];
    logic [7:0] ex [3];
    logic [1:0] hs [4];
    int n_errors = 0, n_tests = 0, cnt;
    wire logic woke = svc | rsm;

    always #5 clk = ~clk;

    shsp_ctrl #(.WARM_MID(20), .WARM_LONG(40)) u_dut (.clk_in(clk), .sys_rst_in(rst),
        .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(ws), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr_r), .s_axi_bresp_out(br_s),
        .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr_s), .s_axi_rvalid_out(rv_o),
        .s_axi_rready_in(rr), .halt_exec_in(hx), .interrupt_mask_level_in(msk), .irq_level_in(lvl),
        .watchdog_irq_in(wdg), .clock_timer_irq_in(ct), .periph_irq_in(1'b0), .nmi_in(nmi),
        .ext_irq_low_group_in(low), .ext_irq_high_group_in(4'h0), .cpu_stop_out(stp), .sys_clk_en_out(sclk),
        .osc_en_out(osc), .clock_timer_run_out(ctr), .port_hold_out(ph), .periph_run_out(prun),
        .wake_service_out(svc), .wake_resume_out(rsm), .irq_held_out(held), .protect_on_out(prot));

    shsp_cpu_model u_cpu (.clk_in(clk), .sys_rst_in(rst), .go_in(go), .req_in(req), .woke_in(woke),
        .halt_exec_out(hx), .clock_timer_irq_out(ct));

    // Xorshift source
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Bus write, held until each channel is taken
    task automatic wrt(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        @(posedge clk);
        while (awr !== 1'b1) @(posedge clk);
        awv <= 1'b0; wv <= 1'b0;
        while (bv !== 1'b1) @(posedge clk);
        br <= 1'b0; rsp = br_s;
    endtask

    // Bus read
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        @(posedge clk);
        while (arr !== 1'b1) @(posedge clk);
        arv <= 1'b0;
        while (rv_o !== 1'b1) @(posedge clk);
        rr <= 1'b0; rv = rdat; rsp = rr_s;
    endtask

    // Counts, verdict and end of run
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    // Main sequence
    initial begin
        {awv, wv, br, arv, rr, go, req, nmi, wdg, awa, ara, wd, msk, lvl, low} = '0;
        ws = 4'hf;
        pa = '{`SHSP_ADDR_SC0, `SHSP_ADDR_FLASH, `SHSP_ADDR_BANK};
        ex = '{8'h00, 8'h00, 8'h00};
        hs = '{`SHSP_HALT_LIGHT, `SHSP_HALT_DEEP, `SHSP_HALT_STOP, `SHSP_HALT_DEEP};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(`SHSP_ADDR_NOISE); chk(rv, 32'h03);
        rd(`SHSP_ADDR_SC2); chk(rv, 32'h2c);
        chk(prot, 1'b0);
        rd(8'h80);
        chk(rsp, 2'b10);
        chk(rv, 32'h0);
        wrt(`SHSP_ADDR_KEY, rnd() | 32'h20); chk(prot, 1'b1);
        rd(`SHSP_ADDR_NOISE); chk(rv[5], 1'b1);
        for (int i = 0; i < 3; i++) begin
            wrt(pa[i], rnd()); chk(rsp, 2'b00);
            rd(pa[i]); chk(rv, ex[i]);
        end
        wrt(`SHSP_ADDR_KEY, 32'h1f); chk(prot, 1'b0);
        for (int i = 0; i < 3; i++) begin
            ex[i] = rnd();
            wrt(pa[i], ex[i]);
            rd(pa[i]); chk(rv, ex[i]);
        end
        for (int i = 0; i < 4; i++) begin
            en = rnd() | 11'h030;
            wrt(`SHSP_ADDR_IDLE, en);
            wrt(`SHSP_ADDR_SC2, {26'h0, 2'b10, hs[i], 2'b00});
            msk <= 3'h3;
            lvl <= (i == 0) ? 3'h3 : 3'h0;
            @(posedge clk); go <= 1'b1;
            wdg <= i == 1;
            @(posedge clk); go <= 1'b0;
            low <= {4'h0, i == 1};
            @(posedge clk); low <= 5'h00;
            repeat (9) @(posedge clk);
            chk({stp, ph}, 2'b11);
            chk(held, (i == 1) ? 11'h002 : 11'h000);
            if (i == 0) chk({sclk, prun}, {1'b1, en});
            if (i[0]) chk({sclk, osc, ctr, prun}, {3'b011, 11'h0});
            if (i == 2) chk({sclk, osc, ctr}, 3'b000);
            if (i == 2) low <= 5'h01;
            else if (i == 3) nmi <= 1'b1;
            else req <= 1'b1;
            @(posedge clk); req <= 1'b0;
            cnt = 0;
            while (woke !== 1'b1 && cnt < 200) begin
                @(posedge clk);
                cnt++;
            end
            chk({svc, rsm}, (i == 0 || i == 3) ? 2'b10 : 2'b01);
            if (i == 2) chk(cnt >= 20, 1'b1);
            {low, nmi, wdg} <= '0;
            repeat (2) @(posedge clk);
            chk({stp, sclk, ph}, 3'b010);
            chk(held, 11'h000);
            rd(pa[0]); chk(rv, ex[0]);
        end
        // Reset released from stop, held past the long warm-up
        wrt(`SHSP_ADDR_SC2, {26'h0, 2'b10, `SHSP_HALT_STOP, 2'b00});
        @(posedge clk); go <= 1'b1;
        @(posedge clk); go <= 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b1;
        repeat (45) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({stp, sclk, osc, prot}, 4'b0110);
        rd(`SHSP_ADDR_SC2); chk(rv, 32'h2c);
        give_verdict();
    end
endmodule
